// >>> hdl/pms_proximity_sequencer.sv
/*
 Proximity measure sequencer: registers, measurement phases, emitter
 pulse timing, persistence and interrupt pin.
 Assumes an on-chip converter on core_clk and a pin level for overload.
*/
// How it works
// - Measuring stays off until shutdown cleared
// - Period selectable from 8 to 64 ms
// - One-T pulse lasts 50 us total
// - Pulse stretches in T steps to 8T
// - Pulse ends with low-current tail step
// - Forced bit, shutdown clear, trigger: one measurement
// - Forced idle keeps only serial port awake
// - Delay, ambient suppression, measure, emitter shutdown
// - No measurement before 2.5 ms start-up
// - Nine 16-bit registers by command code
// - Serial port works at standard and high speed
// - Write: address, command, two data bytes
// - Read: command, repeated start, two bytes back
// - Emitter current at code 0x04
// - Upper threshold low 0x05, high 0x06
// - Event above upper or below lower threshold
// - Event sets flag in 0xF3, pulls pin low
// - Event needs 1 to 4 consecutive hits
// - Sun cancel enable and four strength steps
// - Protection flag under excessive infrared level
// - Interval field bits 7:6 encodes period
// - Persistence field bits 5:4 encodes 1..4
// - Mode bits 3:2: off, off, on, logic
// - Shutdown bit 0, resets to one
`timescale 1ns/10ps
module pms_proximity_sequencer import pms_pkg::*; #(
	parameter int BOOT_CYCLES = BOOT_CYC,
	parameter int PERIOD_CYCLES = PERIOD_CYC,
	parameter int ADC_W = 12,
	parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Serial link
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Open-drain interrupt pin
	output logic irq_o,
	output logic irq_oe,
	// Emitter and front end
	output logic emitter_main,
	output logic emitter_tail,
	output logic [2:0] emitter_drive_level,
	output logic dc_kill,
	output logic adc_conv,
	output logic meas_standby,
	output logic sun_cancel_enable,
	output logic [1:0] sun_cancel_strength,
	input wire logic [ADC_W-1:0] adc_data,
	input wire logic ir_overload_i
);
	pms_req_t req; // Request from serial port
	logic wr_tgl, rd_tgl;
	logic [2:0] wr_s_ff, rd_s_ff; // Toggle synchronisers
	logic [1:0] sun_s_ff; // Overload pin synchroniser
	logic wr_ev, rd_ev;
	logic [15:0] rd_data_ff, rd_val;
	logic rd_ack_ff;
	pms_cfg_a_t cfg_a_ff; // Interval, persistence, mode, shutdown
	logic [15:0] cfg_c_ff, emit_ff, up_lo_ff, up_hi_ff, dn_lo_ff, dn_hi_ff;
	logic [15:0] res_ff; // Last proximity result
	logic [TMR_W-1:0] boot_cnt_ff, per_cnt_ff, tm_ff, nxt_tm, per_len;
	logic boot_done_ff;
	pms_seq_t st_ff, nxt_st;
	logic go, forced, meas_end;
	logic emit_main_ff, emit_tail_ff, dc_kill_ff, adc_conv_ff, standby_ff;
	logic [15:0] up_thr, dn_thr, adc_ext;
	logic above, below, ev_hi, ev_lo;
	logic [2:0] hi_cnt_ff, lo_cnt_ff; // Consecutive hit counters
	logic [1:0] flags_ff, nxt_flags;
	logic logic_ff, nxt_logic, irq_oe_ff;

	// Serial target on the link clock
	pms_i2c_target #(.TARGET_ADDR(TARGET_ADDR)) u_port (
		.link_clk(link_clk),
		.rst_b(rst_b),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.req(req),
		.wr_tgl(wr_tgl),
		.rd_tgl(rd_tgl),
		.rd_data(rd_data_ff),
		.rd_ack_tgl(rd_ack_ff)
	);

	// Outputs from flops; interrupt pin level tied low
	assign irq_o = 1'b0;
	assign irq_oe = irq_oe_ff;
	assign emitter_main = emit_main_ff;
	assign emitter_tail = emit_tail_ff;
	assign emitter_drive_level = emit_ff[2:0];
	assign dc_kill = dc_kill_ff;
	assign adc_conv = adc_conv_ff;
	assign meas_standby = standby_ff;
	assign sun_cancel_enable = cfg_c_ff[CFGC_SC_EN];
	assign sun_cancel_strength = cfg_c_ff[CFGC_SC_STR +: 2];

	// Crossing events from the link domain
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_s_ff <= 3'h0;
			rd_s_ff <= 3'h0;
			sun_s_ff <= 2'h0;
		end else begin
			wr_s_ff <= {wr_s_ff[1:0], wr_tgl};
			rd_s_ff <= {rd_s_ff[1:0], rd_tgl};
			sun_s_ff <= {sun_s_ff[0], ir_overload_i};
		end
	end
	assign wr_ev = wr_s_ff[2] ^ wr_s_ff[1];
	assign rd_ev = rd_s_ff[2] ^ rd_s_ff[1];

	// Read value by command code
	always_comb begin
		case (req.cmd)
			CMD_CFG_C: rd_val = cfg_c_ff;
			CMD_CFG_A: rd_val = cfg_a_ff;
			CMD_EMIT: rd_val = emit_ff;
			CMD_UP_LO: rd_val = up_lo_ff;
			CMD_UP_HI: rd_val = up_hi_ff;
			CMD_DN_LO: rd_val = dn_lo_ff;
			CMD_DN_HI: rd_val = dn_hi_ff;
			CMD_RESULT: rd_val = res_ff;
			CMD_FLAGS: rd_val = {13'h0000, sun_s_ff[1], flags_ff};
			default: rd_val = 16'h0000;
		endcase
	end

	// Answer a read request, toggle back
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= 16'h0000;
			rd_ack_ff <= 1'b0;
		end else if (rd_ev) begin
			rd_data_ff <= rd_val;
			rd_ack_ff <= ~rd_ack_ff;
		end
	end

	// Register writes; trigger cleared as a run starts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_a_ff <= CFG_A_RST;
			cfg_c_ff <= REG_RST;
			emit_ff <= REG_RST;
			up_lo_ff <= REG_RST;
			up_hi_ff <= REG_RST;
			dn_lo_ff <= REG_RST;
			dn_hi_ff <= REG_RST;
		end else begin
			if (go && forced) begin
				cfg_c_ff[CFGC_TRIG] <= 1'b0;
			end
			// A write in the same cycle wins
			if (wr_ev) begin
				case (req.cmd)
					CMD_CFG_C: cfg_c_ff <= req.data;
					CMD_CFG_A: cfg_a_ff <= req.data;
					CMD_EMIT: emit_ff <= req.data;
					CMD_UP_LO: up_lo_ff <= req.data;
					CMD_UP_HI: up_hi_ff <= req.data;
					CMD_DN_LO: dn_lo_ff <= req.data;
					CMD_DN_HI: dn_hi_ff <= req.data;
					default: begin
					end
				endcase
			end
		end
	end

	// Start-up wait
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_cnt_ff <= '0;
			boot_done_ff <= 1'b0;
		end else if (!boot_done_ff) begin
			boot_cnt_ff <= boot_cnt_ff + 1'b1;
			boot_done_ff <= (boot_cnt_ff == TMR_W'(BOOT_CYCLES - 1));
		end
	end

	// Run request: periodic or one forced shot
	assign forced = cfg_c_ff[CFGC_FORCED];
	assign per_len = TMR_W'(PERIOD_CYCLES) << cfg_a_ff.repeat_interval;
	assign go = boot_done_ff && !cfg_a_ff.measure_shutdown && (st_ff == SQ_IDLE) &&
		(forced ? cfg_c_ff[CFGC_TRIG] : (per_cnt_ff == '0));

	// Period counter, one burst per period
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			per_cnt_ff <= '0;
		end else if (!boot_done_ff || cfg_a_ff.measure_shutdown || forced) begin
			per_cnt_ff <= '0;
		end else if (per_cnt_ff != '0) begin
			per_cnt_ff <= per_cnt_ff - 1'b1;
		end else if (st_ff == SQ_IDLE) begin
			per_cnt_ff <= per_len - 1'b1;
		end
	end

	// Phase sequencer
	always_comb begin
		nxt_st = st_ff;
		nxt_tm = tm_ff;
		case (st_ff)
			SQ_IDLE: begin
				if (go) begin
					nxt_st = SQ_DELAY;
					nxt_tm = pms_seg_len(SQ_DELAY, cfg_a_ff.integration_length) - 1'b1;
				end
			end
			SQ_DELAY, SQ_DCKILL, SQ_MEAS, SQ_SHUT: begin
				if (tm_ff != '0) begin
					nxt_tm = tm_ff - 1'b1;
				end else begin
					// Fixed order of phases
					case (st_ff)
						SQ_DELAY: nxt_st = SQ_DCKILL;
						SQ_DCKILL: nxt_st = SQ_MEAS;
						SQ_MEAS: nxt_st = SQ_SHUT;
						default: nxt_st = SQ_IDLE;
					endcase
					nxt_tm = pms_seg_len(nxt_st, cfg_a_ff.integration_length) - 1'b1;
					if (nxt_st == SQ_IDLE) begin
						nxt_tm = '0;
					end
				end
			end
			default: nxt_st = SQ_IDLE;
		endcase
	end
	assign meas_end = (st_ff == SQ_MEAS) && (tm_ff == '0);

	// Phase state and front-end strobes
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= SQ_IDLE;
			tm_ff <= '0;
			emit_main_ff <= 1'b0;
			emit_tail_ff <= 1'b0;
			dc_kill_ff <= 1'b0;
			adc_conv_ff <= 1'b0;
			standby_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			tm_ff <= nxt_tm;
			emit_main_ff <= (nxt_st == SQ_MEAS) && (nxt_tm >= TMR_W'(TAIL_CYC));
			emit_tail_ff <= (nxt_st == SQ_MEAS) && (nxt_tm < TMR_W'(TAIL_CYC));
			dc_kill_ff <= (nxt_st == SQ_DCKILL);
			adc_conv_ff <= (nxt_st == SQ_MEAS);
			standby_ff <= (nxt_st == SQ_IDLE);
		end
	end

	// Threshold compare on each result
	assign up_thr = {up_hi_ff[7:0], up_lo_ff[7:0]};
	assign dn_thr = {dn_hi_ff[7:0], dn_lo_ff[7:0]};
	assign adc_ext = 16'(adc_data);
	assign above = meas_end && (adc_ext > up_thr);
	assign below = meas_end && (adc_ext < dn_thr);
	assign ev_hi = above && (hi_cnt_ff == {1'b0, cfg_a_ff.hit_count_required});
	assign ev_lo = below && (lo_cnt_ff == {1'b0, cfg_a_ff.hit_count_required});

	// Result and consecutive hit counters
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			res_ff <= 16'h0000;
			hi_cnt_ff <= 3'h0;
			lo_cnt_ff <= 3'h0;
		end else if (meas_end) begin
			res_ff <= adc_ext;
			hi_cnt_ff <= above ? ((hi_cnt_ff == 3'h4) ? 3'h4 : hi_cnt_ff + 3'h1) : 3'h0;
			lo_cnt_ff <= below ? ((lo_cnt_ff == 3'h4) ? 3'h4 : lo_cnt_ff + 3'h1) : 3'h0;
		end
	end

	// Flags: set wins over read clear
	always_comb begin
		nxt_flags = flags_ff;
		nxt_logic = logic_ff;
		if (rd_ev && req.cmd == CMD_FLAGS) begin
			nxt_flags = 2'h0;
		end
		if (cfg_a_ff.irq_mode_select[1]) begin
			if (ev_hi) begin
				nxt_flags[FLAG_CLOSE] = 1'b1;
				nxt_logic = 1'b1;
			end
			if (ev_lo) begin
				nxt_flags[FLAG_AWAY] = 1'b1;
				nxt_logic = 1'b0;
			end
		end
	end

	// Flags and open-drain pin
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flags_ff <= 2'h0;
			logic_ff <= 1'b0;
			irq_oe_ff <= 1'b0;
		end else begin
			flags_ff <= nxt_flags;
			logic_ff <= nxt_logic;
			case (cfg_a_ff.irq_mode_select)
				IRQ_ENABLE: irq_oe_ff <= |nxt_flags;
				IRQ_LOGIC: irq_oe_ff <= nxt_logic;
				default: irq_oe_ff <= 1'b0;
			endcase
		end
	end

	// Length of the current emitter pulse, cleared to zero between pulses
	logic [TMR_W-1:0] pulse_cnt_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pulse_cnt_ff <= '0;
		end else begin
			pulse_cnt_ff <= (emit_main_ff | emit_tail_ff) ? pulse_cnt_ff + 1'b1 : '0;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	chk_shutdown_holds: assert property (
		(st_ff == SQ_IDLE) && cfg_a_ff.measure_shutdown |=> (st_ff == SQ_IDLE) && standby_ff)
		else $error("measurement started while shut down");
	chk_boot_wait: assert property (
		!boot_done_ff |-> (st_ff == SQ_IDLE) && !emit_main_ff)
		else $error("activity before start-up wait");
	chk_period_reload: assert property (
		go && !forced |=> per_cnt_ff == per_len - 1'b1)
		else $error("period not reloaded at burst start");
	chk_pulse_length: assert property (
		$fell(emit_main_ff | emit_tail_ff) |->
		pulse_cnt_ff == pms_seg_len(SQ_MEAS, cfg_a_ff.integration_length))
		else $error("emitter pulse length wrong");
	chk_tail_step: assert property (
		$fell(emit_main_ff) |-> emit_tail_ff ##1 emit_tail_ff)
		else $error("pulse ended without low step");
	chk_phase_order: assert property (
		(st_ff == SQ_DCKILL) && (tm_ff == '0) |=> adc_conv_ff && !dc_kill_ff && emit_main_ff)
		else $error("measure did not follow suppression");
	chk_forced_once: assert property (
		(st_ff == SQ_SHUT) && (tm_ff == '0) && forced && !cfg_c_ff[CFGC_TRIG] && !wr_ev
		|=> (st_ff == SQ_IDLE) [*2])
		else $error("forced mode ran more than once");
	chk_standby_idle: assert property (
		(st_ff == SQ_IDLE) [*2] |-> standby_ff && !dc_kill_ff && !adc_conv_ff)
		else $error("front end awake while idle");
	chk_pin_follows: assert property (
		(cfg_a_ff.irq_mode_select == IRQ_ENABLE) && $rose(flags_ff[FLAG_CLOSE]) |-> irq_oe_ff)
		else $error("flag set but pin released");
	chk_hits_needed: assert property (
		$rose(flags_ff[FLAG_CLOSE]) |-> $past(hi_cnt_ff) == {1'b0, cfg_a_ff.hit_count_required})
		else $error("flag set with wrong hit count");

	cov_periodic: cover property (go && !forced);
	cov_forced: cover property (go && forced);
	cov_irq_pin: cover property ($rose(irq_oe_ff));
endmodule : pms_proximity_sequencer

// >>> hdl/pms_pkg.sv
/*
 Shared constants and types of the proximity measure sequencer.
 Assumes a 50 ns core clock; all cycle counts derive from it.
*/
package pms_pkg;
	// Core clock period
	localparam int CORE_PERIOD_NS = 50;
	// Base integration unit T, rounded up
	localparam int T_UNIT_NS = 50000;
	localparam int T_UNIT_CYC = (T_UNIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// Low-current trailing step of each pulse
	localparam int TAIL_NS = 10000;
	localparam int TAIL_CYC = (TAIL_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// Start-up wait before any measurement
	localparam int BOOT_NS = 2500000;
	localparam int BOOT_CYC = (BOOT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	// Shortest repetition period, 8 ms
	localparam int PERIOD_NS = 8000000;
	localparam int PERIOD_CYC = PERIOD_NS / CORE_PERIOD_NS;
	// Timer width
	localparam int TMR_W = 24;
	// Command codes
	localparam logic [7:0] CMD_CFG_C = 8'h02;
	localparam logic [7:0] CMD_CFG_A = 8'h03;
	localparam logic [7:0] CMD_EMIT = 8'h04;
	localparam logic [7:0] CMD_UP_LO = 8'h05;
	localparam logic [7:0] CMD_UP_HI = 8'h06;
	localparam logic [7:0] CMD_DN_LO = 8'h07;
	localparam logic [7:0] CMD_DN_HI = 8'h08;
	localparam logic [7:0] CMD_RESULT = 8'hF2;
	localparam logic [7:0] CMD_FLAGS = 8'hF3;
	// Reset values
	localparam logic [15:0] CFG_A_RST = 16'h0001;
	localparam logic [15:0] REG_RST = 16'h0000;
	// Field positions in proximity_config_c
	localparam int CFGC_TRIG = 0;
	localparam int CFGC_FORCED = 1;
	localparam int CFGC_SC_EN = 2;
	localparam int CFGC_SC_STR = 3;
	// Field positions in interrupt_flags
	localparam int FLAG_AWAY = 0;
	localparam int FLAG_CLOSE = 1;
	localparam int FLAG_SUN = 2;
	// Interrupt modes
	localparam logic [1:0] IRQ_ENABLE = 2'h2;
	localparam logic [1:0] IRQ_LOGIC = 2'h3;

	// Layout of proximity_config_a
	typedef struct packed {
		logic [4:0] spare;
		logic [2:0] integration_length;
		logic [1:0] repeat_interval;
		logic [1:0] hit_count_required;
		logic [1:0] irq_mode_select;
		logic smart_pers;
		logic measure_shutdown;
	} pms_cfg_a_t;

	// Register request from the serial port
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] data;
	} pms_req_t;

	// Measurement phases
	typedef enum {SQ_IDLE, SQ_DELAY, SQ_DCKILL, SQ_MEAS, SQ_SHUT} pms_seq_t;

	// Cycles of one phase for a given integration length
	function automatic logic [TMR_W-1:0] pms_seg_len(input pms_seq_t s, input logic [2:0] itl);
		logic [TMR_W-1:0] it;
		it = TMR_W'((itl + 4'h1) * T_UNIT_CYC);
		case (s)
			SQ_DELAY: pms_seg_len = it >> 1;
			SQ_DCKILL: pms_seg_len = TMR_W'(it * 3);
			default: pms_seg_len = it;
		endcase
	endfunction : pms_seg_len
endpackage : pms_pkg

// >>> hdl/pms_i2c_target.sv
/*
 Serial target port on the link clock: bytes in, register requests out.
 Assumes link_clk oversamples SCL and SDA; replies cross by toggles.
*/
`timescale 1ns/10ps
module pms_i2c_target import pms_pkg::*; #(
	parameter logic [6:0] TARGET_ADDR = 7'h2A
) (
	// Link clock and reset
	input wire logic link_clk,
	input wire logic rst_b,
	// Serial pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Requests toward the core
	output pms_req_t req,
	output logic wr_tgl,
	output logic rd_tgl,
	// Read answer from the core
	input wire logic [15:0] rd_data,
	input wire logic rd_ack_tgl
);
	// Protocol states
	typedef enum {I_IDLE, I_ADDR, I_CMD, I_WDATA, I_ACK, I_TX, I_MACK} pms_i2c_st_t;
	pms_i2c_st_t st_ff, after_ff;
	logic [1:0] scl_s_ff, sda_s_ff; // Pin synchronisers
	logic scl_q_ff, sda_q_ff; // Delayed synced pins
	logic [2:0] ack_s_ff; // Answer toggle synchroniser
	logic [3:0] cnt_ff; // Bit counter
	logic [7:0] sh_ff, tx_ff; // Receive and send shifters
	logic [1:0] idx_ff; // Data byte index
	logic oe_ff, nack_ff, wr_ff, rd_ff;
	pms_req_t req_ff;
	logic [15:0] rd_buf_ff; // Captured read word
	logic [7:0] tx_byte;
	logic scl_rise, scl_fall, start_c, stop_c;

	assign sda_o = 1'b0;
	assign sda_oe = oe_ff;
	assign req = req_ff;
	assign wr_tgl = wr_ff;
	assign rd_tgl = rd_ff;
	// Bus conditions from second sync stage only
	assign scl_rise = scl_s_ff[1] & ~scl_q_ff;
	assign scl_fall = ~scl_s_ff[1] & scl_q_ff;
	assign start_c = scl_s_ff[1] & scl_q_ff & ~sda_s_ff[1] & sda_q_ff;
	assign stop_c = scl_s_ff[1] & scl_q_ff & sda_s_ff[1] & ~sda_q_ff;
	// Low byte first, idle ones past the word
	assign tx_byte = (idx_ff == 2'h0) ? rd_buf_ff[7:0] : (idx_ff == 2'h1) ? rd_buf_ff[15:8] : 8'hFF;

	// Pin and answer synchronisers
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s_ff <= 2'h3;
			sda_s_ff <= 2'h3;
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
			ack_s_ff <= 3'h0;
		end else begin
			scl_s_ff <= {scl_s_ff[0], scl_i};
			sda_s_ff <= {sda_s_ff[0], sda_i};
			scl_q_ff <= scl_s_ff[1];
			sda_q_ff <= sda_s_ff[1];
			ack_s_ff <= {ack_s_ff[1:0], rd_ack_tgl};
		end
	end

	// Catch the read word when the core answers
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_buf_ff <= 16'h0000;
		end else if (ack_s_ff[2] ^ ack_s_ff[1]) begin
			rd_buf_ff <= rd_data;
		end
	end

	// Byte protocol: address, command, data, acknowledge
	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= I_IDLE;
			after_ff <= I_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			idx_ff <= 2'h0;
			oe_ff <= 1'b0;
			nack_ff <= 1'b0;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			req_ff <= '0;
		end else if (start_c) begin
			// Start or repeated start
			st_ff <= I_ADDR;
			cnt_ff <= 4'h0;
			oe_ff <= 1'b0;
		end else if (stop_c) begin
			st_ff <= I_IDLE;
			oe_ff <= 1'b0;
		end else if (scl_rise) begin
			// Sample data, or the controller acknowledge
			if (st_ff == I_ADDR || st_ff == I_CMD || st_ff == I_WDATA) begin
				sh_ff <= {sh_ff[6:0], sda_s_ff[1]};
				cnt_ff <= cnt_ff + 4'h1;
			end
			if (st_ff == I_MACK) begin
				nack_ff <= sda_s_ff[1];
			end
		end else if (scl_fall) begin
			case (st_ff)
				I_ADDR, I_CMD, I_WDATA: begin
					if (cnt_ff == 4'h8) begin
						cnt_ff <= 4'h0;
						oe_ff <= 1'b1;
						st_ff <= I_ACK;
						after_ff <= I_WDATA;
						if (st_ff == I_ADDR) begin
							idx_ff <= 2'h0;
							after_ff <= sh_ff[0] ? I_TX : I_CMD;
							if (sh_ff[7:1] != TARGET_ADDR) begin
								oe_ff <= 1'b0;
								st_ff <= I_IDLE;
							end
						end else if (st_ff == I_CMD) begin
							req_ff.cmd <= sh_ff;
							rd_ff <= ~rd_ff;
							idx_ff <= 2'h0;
						end else begin
							// Low byte then high byte; extras ignored
							if (idx_ff == 2'h0) begin
								req_ff.data[7:0] <= sh_ff;
							end
							if (idx_ff == 2'h1) begin
								req_ff.data[15:8] <= sh_ff;
								wr_ff <= ~wr_ff;
							end
							if (idx_ff != 2'h2) begin
								idx_ff <= idx_ff + 2'h1;
							end
						end
					end
				end
				I_ACK: begin
					oe_ff <= 1'b0;
					st_ff <= after_ff;
					if (after_ff == I_TX) begin
						tx_ff <= tx_byte;
						oe_ff <= ~tx_byte[7];
						cnt_ff <= 4'h1;
					end
				end
				I_TX: begin
					if (cnt_ff == 4'h8) begin
						oe_ff <= 1'b0;
						st_ff <= I_MACK;
						if (idx_ff != 2'h2) begin
							idx_ff <= idx_ff + 2'h1;
						end
					end else begin
						oe_ff <= ~tx_ff[6];
						tx_ff <= {tx_ff[6:0], 1'b0};
						cnt_ff <= cnt_ff + 4'h1;
					end
				end
				I_MACK: begin
					// Controller refusal ends the read
					if (nack_ff) begin
						st_ff <= I_IDLE;
					end else begin
						tx_ff <= tx_byte;
						oe_ff <= ~tx_byte[7];
						cnt_ff <= 4'h1;
						st_ff <= I_TX;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule : pms_i2c_target

// >>> sim/pms_host_model.sv
/*
 Serial bus controller model standing in for the host of the sequencer.
 Assumes the bench resolves the data wire with a pull-up from both pull-downs.
*/
`timescale 1ns/10ps
module pms_host_model #(
	parameter int Q = 250
) (
	// Bus pins, clock idles high, data released outside frames
	output logic scl = 1'b1,
	output logic sda_pull = 1'b0,
	input wire logic sda
);
	// One bit: data set while clock low, sampled in the high phase
	task automatic bit_io(input logic b, output logic r);
		sda_pull = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask : bit_io
	// Start or repeated start: data falls while clock high
	task automatic start_cond();
		sda_pull = 1'b0;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask : start_cond
	// Stop: data rises while clock high, then the bus stands still
	task automatic stop_cond();
		sda_pull = 1'b1;
		#Q scl = 1'b1;
		#Q sda_pull = 1'b0;
		#Q;
	endtask : stop_cond
	// Byte, top bit first, then the acknowledge slot
	task automatic byte_io(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic nak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], r);
			rx[i] = r;
		end
		bit_io(ack, nak);
	endtask : byte_io
	// Register write: address, command, low byte, high byte
	task automatic wr(input logic [6:0] adr, input logic [7:0] cmd, input logic [15:0] d, output logic nak);
		logic [7:0] rx;
		logic [3:0] n;
		start_cond();
		byte_io({adr, 1'b0}, 1'b1, rx, n[0]);
		byte_io(cmd, 1'b1, rx, n[1]);
		byte_io(d[7:0], 1'b1, rx, n[2]);
		byte_io(d[15:8], 1'b1, rx, n[3]);
		stop_cond();
		nak = |n;
	endtask : wr
	// Register read: command, repeated start, two bytes back
	task automatic rd(input logic [6:0] adr, input logic [7:0] cmd, output logic [15:0] d, output logic nak);
		logic [7:0] rx;
		logic [3:0] n;
		start_cond();
		byte_io({adr, 1'b0}, 1'b1, rx, n[0]);
		byte_io(cmd, 1'b1, rx, n[1]);
		start_cond();
		byte_io({adr, 1'b1}, 1'b1, rx, n[2]);
		byte_io(8'hFF, 1'b0, d[7:0], n[3]);
		byte_io(8'hFF, 1'b1, d[15:8], n[3]);
		stop_cond();
		nak = |n[2:0];
	endtask : rd
endmodule : pms_host_model

// >>> sim/pms_proximity_sequencer_tb.sv
/*
 Self-checking bench of the proximity measure sequencer.
 Assumes the host model drives the serial pins; pull-ups are modelled here.
*/
`timescale 1ns/10ps
module pms_proximity_sequencer_tb import pms_pkg::*;;
	localparam int BOOT = 200;
	localparam int PER = 8000;
	localparam logic [6:0] ADR = 7'h2A;
	// Row: command, write flag, value written, value read back
	typedef struct packed {
		logic [7:0] cmd;
		logic wr;
		logic [15:0] wd;
		logic [15:0] rd;
	} pms_row_t;
	localparam pms_row_t ROWS [8] = '{'{CMD_CFG_A, 1'b0, 16'h0000, CFG_A_RST}, '{CMD_EMIT, 1'b0, 16'h0000, REG_RST},
		'{CMD_EMIT, 1'b1, 16'h0005, 16'h0005}, '{CMD_UP_LO, 1'b1, 16'h00F4, 16'h00F4},
		'{CMD_UP_HI, 1'b1, 16'h0001, 16'h0001}, '{CMD_DN_LO, 1'b1, 16'h0064, 16'h0064},
		'{CMD_CFG_C, 1'b1, 16'h001C, 16'h001C}, '{8'h10, 1'b1, 16'h1234, 16'h0000}};
	// Clocks, reset, front-end inputs
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] adc_data = 12'h000;
	logic ir_overload_i = 1'b0;
	// Serial wire with pull-up
	logic scl, pull, sda_oe, sda_o;
	wire logic sda = ~(pull | sda_oe);
	// Design outputs
	logic irq_o, irq_oe, emitter_main, emitter_tail, dc_kill, adc_conv, meas_standby, sun_cancel_enable;
	logic [2:0] emitter_drive_level;
	logic [1:0] sun_cancel_strength;
	// Counters and pulse monitor state
	int failures = 0, comparisons = 0, pulses = 0, gap = 0, since = 0;
	int on_len = 0, tail_len = 0, last_on = 0, last_tail = 0, dc_len = 0, p;
	logic em_ff = 1'b0, dk_ff = 1'b0, nak;
	logic [15:0] v;

	// Core clock 50 ns, link clock 30 ns
	always #25 core_clk = ~core_clk;
	always #15 link_clk = ~link_clk;

	pms_proximity_sequencer #(.BOOT_CYCLES(BOOT), .PERIOD_CYCLES(PER)) i_dut (.core_clk(core_clk), .rst_b(rst_b),
		.link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq_o(irq_o),
		.irq_oe(irq_oe), .emitter_main(emitter_main), .emitter_tail(emitter_tail), .dc_kill(dc_kill),
		.emitter_drive_level(emitter_drive_level), .adc_conv(adc_conv), .meas_standby(meas_standby),
		.sun_cancel_enable(sun_cancel_enable), .sun_cancel_strength(sun_cancel_strength),
		.adc_data(adc_data), .ir_overload_i(ir_overload_i));
	pms_host_model i_host (.scl(scl), .sda_pull(pull), .sda(sda));

	// Pulse monitor: spacing, lit length and tail length of each pulse
	always @(posedge core_clk) begin
		em_ff <= emitter_main;
		dk_ff <= dc_kill;
		since <= since + 1;
		if (emitter_main && !em_ff) begin
			pulses <= pulses + 1;
			gap <= since;
			since <= 1;
			last_on <= on_len;
			last_tail <= tail_len;
			on_len <= 1;
			tail_len <= 0;
		end else begin
			on_len <= on_len + int'(emitter_main | emitter_tail);
			tail_len <= tail_len + int'(emitter_tail);
		end
		dc_len <= (dc_kill && !dk_ff) ? 1 : dc_len + int'(dc_kill);
	end

	// Compare and count
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Counts, verdict, end of run
	task automatic test_done();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	// Bounded wait for a pulse count, or for standby when idle is set
	task automatic wait_for(input int n, input logic idle);
		int k;
		k = 0;
		while ((idle ? meas_standby !== 1'b1 : pulses < n) && k < 40000) begin
			@(negedge core_clk);
			k++;
		end
		if (k >= 40000) begin
			failures++;
			test_done();
		end
	endtask : wait_for
	// Register read against an expected value
	task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
		i_host.rd(ADR, cmd, v, nak);
		chk($sformatf("reg %h", cmd), exp, v);
	endtask : rd_chk

	// Main sequence
	initial begin
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (BOOT) @(negedge core_clk);
		i_host.wr(7'h11, CMD_EMIT, 16'h0007, nak);
		chk("foreign address nak", 16'h0001, 16'(nak));
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) begin
				i_host.wr(ADR, ROWS[i].cmd, ROWS[i].wd, nak);
				chk("write nak", 16'h0000, 16'(nak));
			end
			rd_chk(ROWS[i].cmd, ROWS[i].rd);
		end
		chk("drive level", 16'h0005, 16'(emitter_drive_level));
		chk("sun cancel", 16'h0007, 16'({sun_cancel_enable, sun_cancel_strength}));
		chk("pulses while shut", 16'h0000, 16'(pulses));
		// Periodic 1T, two hits, interrupt on
		@(negedge core_clk);
		adc_data = 12'h258;
		i_host.wr(ADR, CMD_CFG_A, 16'h0018, nak);
		wait_for(2, 1'b0);
		chk("irq one hit", 16'h0000, 16'(irq_oe));
		wait_for(3, 1'b0);
		chk("irq two hits", 16'h0001, 16'(irq_oe));
		chk("irq level", 16'h0000, 16'(irq_o));
		chk("period", 16'(PER), 16'(gap));
		chk("pulse length", 16'(T_UNIT_CYC), 16'(last_on));
		chk("tail length", 16'(TAIL_CYC), 16'(last_tail));
		ir_overload_i = 1'b1;
		rd_chk(CMD_FLAGS, 16'h0006);
		chk("irq after read", 16'h0000, 16'(irq_oe));
		@(negedge core_clk);
		ir_overload_i = 1'b0;
		adc_data = 12'h032;
		wait_for(6, 1'b0);
		chk("irq below lower", 16'h0001, 16'(irq_oe));
		rd_chk(CMD_FLAGS, 16'h0001);
		// Forced single shot at 2T
		i_host.wr(ADR, CMD_CFG_A, 16'h0101, nak);
		wait_for(0, 1'b1);
		i_host.wr(ADR, CMD_CFG_C, 16'h0002, nak);
		i_host.wr(ADR, CMD_CFG_A, 16'h0100, nak);
		p = pulses;
		i_host.wr(ADR, CMD_CFG_C, 16'h0003, nak);
		wait_for(p + 1, 1'b0);
		wait_for(0, 1'b1);
		chk("forced pulse", 16'(2 * T_UNIT_CYC), 16'(on_len));
		chk("suppression", 16'(6 * T_UNIT_CYC), 16'(dc_len));
		repeat (PER) @(negedge core_clk);
		chk("one shot only", 16'(p + 1), 16'(pulses));
		chk("standby", 16'h0001, 16'(meas_standby));
		chk("data level", 16'h0000, 16'(sda_o));
		// Mid-run reset: outputs idle, registers back to reset values
		rst_b = 1'b0;
		@(negedge core_clk);
		@(negedge core_clk);
		chk("standby in reset", 16'h0001, 16'(meas_standby));
		chk("irq in reset", 16'h0000, 16'(irq_oe));
		rst_b = 1'b1;
		rd_chk(CMD_CFG_A, CFG_A_RST);
		rd_chk(CMD_CFG_C, REG_RST);
		test_done();
	end
endmodule : pms_proximity_sequencer_tb
